// *** eepti_consts.svh ***
// Constants for the puncturing and time-interleaving back end.
// Assumes inclusion by bare name from the design module.
`ifndef EEPTI_CONSTS_SVH
`define EEPTI_CONSTS_SVH
`define EEPTI_BLOCK_BITS 128
`define EEPTI_BLOCK_SHIFT 7
`define EEPTI_TAIL_BITS 24
`define EEPTI_BRANCHES 16
`define EEPTI_LAST_DELAY 15
`define EEPTI_FRAME_MOD 5000
`define EEPTI_A_MAX_N 216
`define EEPTI_B_MAX_N 57
`define EEPTI_A_INFO_MULT 192
`define EEPTI_B_INFO_MULT 768
`define EEPTI_A_BLK_MULT 6
`define EEPTI_B_BLK_MULT 24
`endif

// *** eepti_pkg.sv ***
// Types shared by the puncturing and time-interleaving back end.
// Assumes nothing beyond a SystemVerilog compiler.
package eepti_pkg;
  typedef enum logic [2:0] {
    EEPTI_IDLE = 3'b001,
    EEPTI_FILL = 3'b010,
    EEPTI_DRAIN = 3'b100
  } eepti_state_e;

  typedef enum logic {
    EEPTI_SET_A = 1'b0,
    EEPTI_SET_B = 1'b1
  } eepti_set_e;
endpackage : eepti_pkg

// *** eepti_core.sv ***
// Equal-error-protection puncturing control and 16-branch time interleaver.
// Assumes an external mother-code encoder feeding serial bits and an
// external puncture-vector lookup answering in the same cycle.
`include "eepti_consts.svh"

// Function
// - One scrambled frame of I bits per frame period is taken; I follows from rate multiple and set.
// - The first 4I mother bits are counted off in consecutive blocks of exactly 128 bits.
// - The first block group uses the first puncture index and the next group the second.
// - The last 24 mother bits use the tail rule and no padding is ever added to the codeword.
// - Set A uses I of 192n and 6n blocks for n up to 216, levels 1 to 4.
// - Set A levels 4 and 3 use block counts 4n-3/2n+3 with 3/2 and 6n-3/3 with 8/7.
// - Set A level 2 uses 5/1 with 13/12 at n of 1, else 2n-3/4n+3 with 14/13; level 1 uses 6n-3/3 with 24/23.
// - Set B uses I of 768n and 24n blocks for n up to 57, levels 1 to 4.
// - Set B uses 24n-3/3 with index pairs 2/1, 4/3, 6/5 and 10/9 for levels 4 to 1.
// - Every main-service frame is interleaved; a fast-information frame passes without interleaving.
// - A frame index counts modulo 5000 from zero at reset.
// - Output bit i comes from the delayed frame if i is below that frame's length, else it is zero.
// - The delay in frames is the bit-reversed value of the bit index modulo 16.
// - The output length of a main-service frame is the larger of its own length and the length 15 frames back; a fast-information frame keeps its own.
module eepti_core #(
  parameter int unsigned CW_W = 18,
  parameter int unsigned N_W = 8
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic frame_start_i,
  input wire logic fic_i,
  input wire logic prot_set_i,
  input wire logic [2:0] prot_level_i,
  input wire logic [N_W-1:0] rate_mult_i,
  output logic frame_ready_o,
  output logic cfg_err_o,
  output logic [CW_W-1:0] info_bits_o,
  input wire logic mother_valid_i,
  input wire logic mother_bit_i,
  output logic mother_ready_o,
  output logic [4:0] puncture_index_o,
  output logic [4:0] punct_pos_o,
  output logic tail_o,
  input wire logic keep_i,
  output logic out_valid_o,
  output logic out_bit_o,
  output logic out_first_o,
  output logic out_last_o,
  output logic [CW_W-1:0] out_len_o,
  output logic [12:0] frame_count_o
);
  localparam int unsigned DEPTH = 1 << CW_W;

  // Branch delay is the 4-bit reversal of the residue
  function automatic logic [3:0] branch_delay(input logic [3:0] res);
    branch_delay = {res[0], res[1], res[2], res[3]};
  endfunction : branch_delay

  function automatic logic [CW_W-1:0] max_len(input logic [CW_W-1:0] a, input logic [CW_W-1:0] b);
    max_len = (a > b) ? a : b;
  endfunction : max_len

  eepti_pkg::eepti_state_e state_q, state_d;
  logic mem [16*DEPTH];
  logic [CW_W-1:0] len_q [16];
  logic [15:0] written_q;
  logic [3:0] slot_q;
  logic [12:0] fcnt_q;
  logic fic_q;
  logic [CW_W-1:0] l1_q, lsum_q, mcnt_q, wcnt_q, rcnt_q, nlen_q;
  logic [4:0] pi1_q, pi2_q;
  logic rd_valid_q, rd_use_q, rd_first_q, rd_last_q;
  logic [CW_W+3:0] rd_addr_q;
  logic out_valid_q, out_bit_q, out_first_q, out_last_q;

  // Profile decode from set, level and rate multiple
  wire logic [CW_W-1:0] n_w = CW_W'(rate_mult_i);
  wire logic set_b = (prot_set_i == eepti_pkg::EEPTI_SET_B);
  wire logic n_ok = (n_w != '0) &&
    (set_b ? (n_w <= CW_W'(`EEPTI_B_MAX_N)) : (n_w <= CW_W'(`EEPTI_A_MAX_N)));
  wire logic lvl_ok = (prot_level_i >= 3'd1) && (prot_level_i <= 3'd4);
  wire logic cfg_ok = n_ok && lvl_ok;
  wire logic [CW_W-1:0] info_w = CW_W'(n_w * (set_b ? `EEPTI_B_INFO_MULT : `EEPTI_A_INFO_MULT));
  wire logic [CW_W-1:0] lsum_w = CW_W'(n_w * (set_b ? `EEPTI_B_BLK_MULT : `EEPTI_A_BLK_MULT));
  logic [CW_W-1:0] l1_w;
  logic [4:0] pi1_w, pi2_w;
  always_comb begin
    l1_w = '0;
    pi1_w = '0;
    pi2_w = '0;
    if (set_b) begin
      l1_w = CW_W'(24 * n_w - 3);
      case (prot_level_i)
        3'd4: begin
          pi1_w = 5'd2;
          pi2_w = 5'd1;
        end
        3'd3: begin
          pi1_w = 5'd4;
          pi2_w = 5'd3;
        end
        3'd2: begin
          pi1_w = 5'd6;
          pi2_w = 5'd5;
        end
        3'd1: begin
          pi1_w = 5'd10;
          pi2_w = 5'd9;
        end
        default: begin
          pi1_w = '0;
          pi2_w = '0;
        end
      endcase
    end else begin
      case (prot_level_i)
        3'd4: begin
          l1_w = CW_W'(4 * n_w - 3);
          pi1_w = 5'd3;
          pi2_w = 5'd2;
        end
        3'd3: begin
          l1_w = CW_W'(6 * n_w - 3);
          pi1_w = 5'd8;
          pi2_w = 5'd7;
        end
        3'd2: begin
          if (n_w == CW_W'(1)) begin
            l1_w = CW_W'(5);
            pi1_w = 5'd13;
            pi2_w = 5'd12;
          end else begin
            l1_w = CW_W'(2 * n_w - 3);
            pi1_w = 5'd14;
            pi2_w = 5'd13;
          end
        end
        3'd1: begin
          l1_w = CW_W'(6 * n_w - 3);
          pi1_w = 5'd24;
          pi2_w = 5'd23;
        end
        default: begin
          l1_w = '0;
          pi1_w = '0;
          pi2_w = '0;
        end
      endcase
    end
  end

  // Puncturing position within the mother codeword
  wire logic [CW_W-1:0] blk_w = mcnt_q >> `EEPTI_BLOCK_SHIFT;
  wire logic [CW_W-1:0] body_w = CW_W'(lsum_q << `EEPTI_BLOCK_SHIFT);
  wire logic in_tail = (mcnt_q >= body_w);
  wire logic [CW_W-1:0] tail_off = mcnt_q - body_w;
  wire logic last_mother = (mcnt_q == body_w + CW_W'(`EEPTI_TAIL_BITS - 1));
  wire logic take_bit = (state_q == eepti_pkg::EEPTI_FILL) && mother_valid_i;
  wire logic store_bit = take_bit && keep_i;
  wire logic start_ok = (state_q == eepti_pkg::EEPTI_IDLE) && frame_start_i && cfg_ok;

  // Interleaver read side
  wire logic [3:0] res_w = rcnt_q[3:0];
  wire logic [3:0] rslot_w = fic_q ? slot_q : slot_q - branch_delay(res_w);
  wire logic src_written = fic_q ? 1'b1 : written_q[rslot_w];
  wire logic [CW_W-1:0] src_len = fic_q ? wcnt_q : len_q[rslot_w];
  wire logic src_in = src_written && (rcnt_q < src_len);
  wire logic [3:0] old_slot = slot_q + 4'd1; // 15 frames back
  wire logic [CW_W-1:0] old_len = written_q[old_slot] ? len_q[old_slot] : '0;
  wire logic drain_go = (state_q == eepti_pkg::EEPTI_DRAIN) && (rcnt_q < nlen_q);

  always_comb begin
    state_d = state_q;
    case (state_q)
      eepti_pkg::EEPTI_IDLE: begin
        if (start_ok) begin
          state_d = eepti_pkg::EEPTI_FILL;
        end
      end
      eepti_pkg::EEPTI_FILL: begin
        if (take_bit && last_mother) begin
          state_d = eepti_pkg::EEPTI_DRAIN;
        end
      end
      eepti_pkg::EEPTI_DRAIN: begin
        if (!drain_go && !rd_valid_q) begin
          state_d = eepti_pkg::EEPTI_IDLE;
        end
      end
      default: state_d = eepti_pkg::EEPTI_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_q <= eepti_pkg::EEPTI_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Frame setup and mother-bit counting
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      mcnt_q <= '0;
      wcnt_q <= '0;
      l1_q <= '0;
      lsum_q <= '0;
      pi1_q <= '0;
      pi2_q <= '0;
      fic_q <= 1'b0;
    end else if (start_ok) begin
      mcnt_q <= '0;
      wcnt_q <= '0;
      l1_q <= l1_w;
      lsum_q <= lsum_w;
      pi1_q <= pi1_w;
      pi2_q <= pi2_w;
      fic_q <= fic_i;
    end else if (take_bit) begin
      mcnt_q <= mcnt_q + CW_W'(1);
      wcnt_q <= wcnt_q + (keep_i ? CW_W'(1) : CW_W'(0));
    end
  end

  // Kept bits written at their codeword index into the frame slot
  always_ff @(posedge mclk_i) begin
    if (store_bit) begin
      mem[{slot_q, wcnt_q}] <= mother_bit_i;
    end
  end

  // Slot bookkeeping and output length at end of fill
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      written_q <= '0;
      nlen_q <= '0;
      for (int k = 0; k < `EEPTI_BRANCHES; k++) begin
        len_q[k] <= '0;
      end
    end else if (take_bit && last_mother) begin
      if (fic_q) begin
        nlen_q <= wcnt_q + (keep_i ? CW_W'(1) : CW_W'(0));
      end else begin
        len_q[slot_q] <= wcnt_q + (keep_i ? CW_W'(1) : CW_W'(0));
        written_q[slot_q] <= 1'b1;
        nlen_q <= max_len(wcnt_q + (keep_i ? CW_W'(1) : CW_W'(0)), old_len);
      end
    end
  end

  // Frame slot and frame index advance after each main-service frame
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      slot_q <= '0;
      fcnt_q <= '0;
    end else if (state_q == eepti_pkg::EEPTI_DRAIN && state_d == eepti_pkg::EEPTI_IDLE && !fic_q) begin
      slot_q <= slot_q + 4'd1;
      fcnt_q <= (fcnt_q == 13'(`EEPTI_FRAME_MOD - 1)) ? 13'd0 : fcnt_q + 13'd1;
    end
  end

  // Read stage: address and selection, then memory bit
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rcnt_q <= '0;
      rd_valid_q <= 1'b0;
      rd_use_q <= 1'b0;
      rd_first_q <= 1'b0;
      rd_last_q <= 1'b0;
      rd_addr_q <= '0;
    end else begin
      rd_valid_q <= drain_go;
      rd_use_q <= src_in;
      rd_first_q <= (rcnt_q == '0);
      rd_last_q <= (rcnt_q == nlen_q - CW_W'(1));
      rd_addr_q <= {rslot_w, rcnt_q};
      if (start_ok) begin
        rcnt_q <= '0;
      end else if (drain_go) begin
        rcnt_q <= rcnt_q + CW_W'(1);
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      out_valid_q <= 1'b0;
      out_bit_q <= 1'b0;
      out_first_q <= 1'b0;
      out_last_q <= 1'b0;
    end else begin
      out_valid_q <= rd_valid_q;
      out_bit_q <= rd_valid_q && rd_use_q && mem[rd_addr_q];
      out_first_q <= rd_valid_q && rd_first_q;
      out_last_q <= rd_valid_q && rd_last_q;
    end
  end

  assign frame_ready_o = (state_q == eepti_pkg::EEPTI_IDLE);
  assign cfg_err_o = !cfg_ok;
  assign info_bits_o = info_w;
  assign mother_ready_o = (state_q == eepti_pkg::EEPTI_FILL);
  assign puncture_index_o = (blk_w < l1_q) ? pi1_q : pi2_q;
  assign punct_pos_o = in_tail ? tail_off[4:0] : mcnt_q[4:0];
  assign tail_o = in_tail;
  assign out_valid_o = out_valid_q;
  assign out_bit_o = out_bit_q;
  assign out_first_o = out_first_q;
  assign out_last_o = out_last_q;
  assign out_len_o = nlen_q;
  assign frame_count_o = fcnt_q;
endmodule : eepti_core

// *** eepti_core_chk.sv ***
// Port-level checks for the puncturing and time-interleaving core.
// Assumes the bind below attaches it to every core instance.
module eepti_core_chk #(
  parameter int unsigned CW_W = 18,
  parameter int unsigned N_W = 8
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic frame_start_i,
  input wire logic prot_set_i,
  input wire logic [2:0] prot_level_i,
  input wire logic [N_W-1:0] rate_mult_i,
  input wire logic frame_ready_o,
  input wire logic cfg_err_o,
  input wire logic [CW_W-1:0] info_bits_o,
  input wire logic mother_valid_i,
  input wire logic mother_ready_o,
  input wire logic [4:0] punct_pos_o,
  input wire logic tail_o,
  input wire logic out_valid_o,
  input wire logic out_first_o,
  input wire logic out_last_o,
  input wire logic [CW_W-1:0] out_len_o,
  input wire logic [12:0] frame_count_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  start_fill_a: assert property (frame_start_i && frame_ready_o && !cfg_err_o |=> mother_ready_o && !frame_ready_o)
    else $error("accepted start did not open fill");
  info_len_a: assert property (!cfg_err_o |-> info_bits_o == CW_W'((prot_set_i ? 768 : 192) * rate_mult_i))
    else $error("info length wrong");
  level_err_a: assert property (prot_level_i == 3'h0 || prot_level_i > 3'h4 || rate_mult_i == '0 |-> cfg_err_o)
    else $error("bad setting not flagged");
  tail_start_a: assert property ($rose(tail_o) |-> punct_pos_o == 5'h00)
    else $error("tail starts off zero");
  tail_end_a: assert property (mother_valid_i && mother_ready_o && tail_o && punct_pos_o == 5'h17 |=> !mother_ready_o)
    else $error("fill not closed after tail");
  run_on_a: assert property (out_valid_o && !out_last_o |=> out_valid_o && !out_first_o && $stable(out_len_o))
    else $error("output run broken");
  run_end_a: assert property (out_last_o |-> out_valid_o ##1 !out_valid_o)
    else $error("output run overlong");
  count_step_a: assert property ($changed(frame_count_o) && !$past(rst_i) |->
    frame_count_o == ($past(frame_count_o) == 13'h1387 ? 13'h0000 : $past(frame_count_o) + 13'h0001))
    else $error("frame index step wrong");
  cover property (frame_start_i && frame_ready_o && !cfg_err_o);
  cover property (out_last_o);
  cover property (tail_o && punct_pos_o == 5'h17);
endmodule : eepti_core_chk
bind eepti_core eepti_core_chk #(.CW_W(CW_W), .N_W(N_W)) i_eepti_core_chk (.*);

// *** eepti_enc_model.sv ***
// Mother-code source model: serial bits with valid, keep answered at once.
// Assumes start_i is high on the edge at which the core takes a frame.
module eepti_enc_model (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic slow_i,
  input wire logic [7:0] tag_i,
  input wire logic mother_ready_i,
  output logic mother_valid_o,
  output logic mother_bit_o,
  output logic keep_o
);
  int k_q;
  function automatic logic pat(input logic [7:0] f, input int k);
    return logic'(((k * 7 + int'(f) * 13) >> 2) & 1);
  endfunction : pat
  // Idle cycles show the inverted bit, not a held one
  assign mother_bit_o = pat(tag_i, k_q) ^ ~mother_valid_o;
  assign keep_o = 1'b1;
  always_ff @(posedge mclk_i) begin
    if (rst_i || start_i) begin
      k_q <= 0;
      mother_valid_o <= 1'b1;
    end else if (mother_valid_o && mother_ready_i) begin
      k_q <= k_q + 1;
      mother_valid_o <= !slow_i;
    end else begin
      mother_valid_o <= 1'b1;
    end
  end
endmodule : eepti_enc_model

// *** test_eep_puncture_time_interleave.sv ***
// Self-checking bench for the puncturing and time-interleaving core.
// Assumes the core, its checker and the source model compile alongside.
module test_eep_puncture_time_interleave;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(g, e) begin checks++; if ((g) !== (e)) begin mismatches++; $display("Error %0t got %h exp %h", $time, g, e); end end
  localparam int unsigned CW_W = 12;
  logic mclk_i = 1'b0, rst_i = 1'b1, frame_start_i = 1'b0, fic_i = 1'b0, prot_set_i = 1'b0, slow = 1'b0, enc_start = 1'b0;
  logic [2:0] prot_level_i = 3'h1;
  logic [7:0] rate_mult_i = 8'h01, tag = 8'h00;
  logic frame_ready_o, cfg_err_o, mother_ready_o, tail_o, out_valid_o, out_bit_o, out_first_o, out_last_o;
  logic mother_valid_i, mother_bit_i, keep_i;
  logic [CW_W-1:0] info_bits_o, out_len_o;
  logic [4:0] puncture_index_o, punct_pos_o;
  logic [12:0] frame_count_o;
  int checks = 0, mismatches = 0, kcnt = 0, plen = 0, pl1 = 0, ppi1 = 0, fcnt = 0, j;
  int mlen [0:31];
  int pa [1:4] = '{24, 14, 8, 3};
  int pb [1:4] = '{10, 6, 4, 2};
  int ecfg [5] = '{'h0501, 'h0001, 'h0100, 'h113a, 'h01d9};
  always #2 mclk_i = ~mclk_i;
  eepti_core #(.CW_W(CW_W), .N_W(8)) i_eepti_core (.*);
  eepti_enc_model i_eepti_enc_model (.mclk_i(mclk_i), .rst_i(rst_i), .start_i(enc_start), .slow_i(slow),
    .tag_i(tag), .mother_ready_i(mother_ready_o), .mother_valid_o(mother_valid_i), .mother_bit_o(mother_bit_i),
    .keep_o(keep_i));
  function automatic logic pat(input logic [7:0] f, input int k);
    return logic'(((k * 7 + int'(f) * 13) >> 2) & 1);
  endfunction : pat
  task test_done;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : test_done
  task automatic wait_idle;
    int t;
    for (t = 0; t < 20000 && frame_ready_o !== 1'b1; t++) @(negedge mclk_i);
  endtask : wait_idle
  task automatic run_frame(input int r, input bit fic, input bit set, input int lvl, input int n);
    int m, nl, i, rp, t;
    logic [3:0] iv;
    logic e;
    wait_idle();
    prot_set_i = set;
    prot_level_i = 3'(lvl);
    rate_mult_i = 8'(n);
    fic_i = fic;
    tag = fic ? 8'hc8 : 8'(r);
    slow = (r % 4 == 1);
    plen = 128 * (set ? 24 * n : 6 * n);
    m = plen + 24;
    ppi1 = set ? pb[lvl] : (lvl == 2 && n == 1) ? 13 : pa[lvl];
    pl1 = (set || lvl == 1 || lvl == 3) ? plen / 128 - 3 : (lvl == 4) ? 4 * n - 3 : (n == 1) ? 5 : 2 * n - 3;
    kcnt = 0;
    @(negedge mclk_i);
    `CHK(frame_count_o, 13'(fcnt))
    `CHK(info_bits_o, CW_W'(set ? 768 * n : 192 * n))
    `CHK(cfg_err_o, 1'b0)
    frame_start_i = 1'b1;
    enc_start = 1'b1;
    @(negedge mclk_i);
    frame_start_i = 1'b0;
    enc_start = 1'b0;
    nl = (!fic && r >= 15 && mlen[r - 15] > m) ? mlen[r - 15] : m;
    if (!fic) mlen[r] = m;
    for (t = 0; t < 20000 && out_valid_o !== 1'b1; t++) @(negedge mclk_i);
    `CHK(out_len_o, CW_W'(nl))
    for (i = 0; i < nl; i++) begin
      iv = i[3:0];
      rp = r - int'({iv[0], iv[1], iv[2], iv[3]});
      e = fic ? pat(8'hc8, i) : (rp >= 0 && i < mlen[rp]) ? pat(8'(rp), i) : 1'b0;
      `CHK(out_bit_o, e)
      `CHK(out_first_o, 1'(i == 0))
      `CHK(out_last_o, 1'(i == nl - 1))
      @(negedge mclk_i);
    end
    `CHK(out_valid_o, 1'b0)
    if (!fic) fcnt++;
  endtask : run_frame
  always @(negedge mclk_i) begin
    if (mother_valid_i === 1'b1 && mother_ready_o === 1'b1) begin
      if (kcnt < plen) `CHK(puncture_index_o, 5'((kcnt >> 7) < pl1 ? ppi1 : ppi1 - 1))
      `CHK(tail_o, 1'(kcnt >= plen))
      `CHK(punct_pos_o, 5'(kcnt >= plen ? kcnt - plen : kcnt))
      kcnt++;
    end
  end
  initial begin
    repeat (5) @(negedge mclk_i);
    rst_i = 1'b0;
    frame_start_i = 1'b1;
    for (j = 0; j < 5; j++) begin
      prot_set_i = ecfg[j][12];
      prot_level_i = ecfg[j][10:8];
      rate_mult_i = ecfg[j][7:0];
      @(negedge mclk_i);
      `CHK(cfg_err_o, 1'b1)
      `CHK(mother_ready_o, 1'b0)
    end
    frame_start_i = 1'b0;
    for (j = 0; j < 4; j++) run_frame(j, 1'b0, 1'b1, j + 1, 1);
    for (j = 4; j < 20; j++) run_frame(j, 1'b0, 1'b0, j % 4 + 1, 1);
    run_frame(20, 1'b1, 1'b0, 2, 1);
    wait_idle();
    @(negedge mclk_i);
    `CHK(frame_count_o, 13'(fcnt))
    test_done();
  end
  initial begin
    repeat (90000) @(posedge mclk_i);
    mismatches++;
    test_done();
  end
endmodule : test_eep_puncture_time_interleave
